// ==== filter_sel_pkg.sv ====
// constants for the per-channel output filter resistor select bank
package filter_sel_pkg;
   localparam int NUM_CH = 6;
   localparam int CODE_W = 4;
   localparam int REG_W = 8;
   localparam int ADDR_W = 8;
   localparam int NUM_LEGS = 6;
   // register offsets on the parallel register strobe port
   localparam logic [7:0] OFS_CH0 = 8'h1d;
   localparam logic [7:0] OFS_CH1 = 8'h1e;
   localparam logic [7:0] OFS_CH2 = 8'h1f;
   localparam logic [7:0] OFS_CH3 = 8'h20;
   localparam logic [7:0] OFS_CH4 = 8'h21;
   localparam logic [7:0] OFS_CH5 = 8'h22;
   // field layout and reset values
   localparam int CODE_LSB = 0;
   localparam int CODE_MSB = 3;
   localparam logic [7:0] FILTER_RESET = 8'h00;
   localparam logic [3:0] RSVD_VALUE = 4'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // resistor select codes
   localparam logic [3:0] CODE_60R = 4'h0;
   localparam logic [3:0] CODE_5K6 = 4'h5;
   localparam logic [3:0] CODE_11K2 = 4'h6;
   localparam logic [3:0] CODE_22K2 = 4'h7;
   localparam logic [3:0] CODE_44K4 = 4'h8;
   localparam logic [3:0] CODE_104K = 4'h9;
   // one-hot resistor leg enables, bit 0 is the 60 ohm leg
   localparam logic [5:0] LEG_60R = 6'h01;
   localparam logic [5:0] LEG_5K6 = 6'h02;
   localparam logic [5:0] LEG_11K2 = 6'h04;
   localparam logic [5:0] LEG_22K2 = 6'h08;
   localparam logic [5:0] LEG_44K4 = 6'h10;
   localparam logic [5:0] LEG_104K = 6'h20;
   localparam logic [5:0] LEG_NONE = 6'h00;
endpackage

// ==== code_store_if.sv ====
// carrier between the register front end and the select code store
`timescale 1ns/1ns
interface code_store_if;
   import filter_sel_pkg::*;
   logic wr_en;
   logic [2:0] wr_ch;
   logic [CODE_W-1:0] wr_code;
   logic [2:0] rd_ch;
   logic [CODE_W-1:0] rd_code;
   logic [NUM_CH-1:0][CODE_W-1:0] codes;
   modport store (input wr_en, wr_ch, wr_code, rd_ch,
      output rd_code, codes);
   modport ctrl (output wr_en, wr_ch, wr_code, rd_ch,
      input rd_code, codes);
endinterface

// ==== code_store.sv ====
// storage for the per-channel resistor select codes, registered read
`timescale 1ns/1ns
module code_store
   import filter_sel_pkg::*;
#(
   parameter int CHANNELS = NUM_CH
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   code_store_if.store port
);
   logic [NUM_CH-1:0][CODE_W-1:0] codes;
   logic [NUM_CH-1:0][CODE_W-1:0] next_codes;
   logic [CODE_W-1:0] rd_code;
   logic [CODE_W-1:0] next_rd_code;

   // the bank and the address window are built for six channels
   if (CHANNELS != NUM_CH)
   begin : g_chk
      $error("code_store: CHANNELS must equal six");
   end

   // write one channel, capture the read word from the old contents
   always_comb
   begin
      next_codes = codes;
      if (port.wr_en && (int'(port.wr_ch) < NUM_CH))
      begin
         next_codes[port.wr_ch] = port.wr_code;
      end
      next_rd_code = RSVD_VALUE;
      if (int'(port.rd_ch) < NUM_CH)
      begin
         next_rd_code = codes[port.rd_ch];
      end
   end

   // every channel starts at the 60 ohm code
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         codes <= '0;
         rd_code <= '0;
      end
      else
      begin
         codes <= next_codes;
         rd_code <= next_rd_code;
      end
   end

   assign port.codes = codes;
   assign port.rd_code = rd_code;
endmodule

// ==== output_filter_select_regs.sv ====
// register bank selecting each channel's output rc filter resistor
//
// How it works
// - each channel register holds a writable 4-bit resistor code in bits 3:0
// - codes 0, 5, 6 pick 60 ohm, 5.6 k and 11.2 k
// - codes 7, 8, 9 pick 22.2 k, 44.4 k and 104 k
// - bits 7:4 are read-only zero, writes there are dropped
// - channels 1 to 5 sit at 0x1e through 0x22
// - every register resets to 0x00, the 60 ohm leg
// - channel 0 sits at 0x1d and also resets to 0x00
`timescale 1ns/1ns
module output_filter_select_regs
   import filter_sel_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [filter_sel_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [filter_sel_pkg::REG_W-1:0] reg_wdata_in,
   output logic [filter_sel_pkg::REG_W-1:0] reg_rdata_out,
   output logic reg_rvalid_out,
   output logic [3:0] ch0_rc_resistor_code_out,
   output logic [3:0] ch1_rc_resistor_code_out,
   output logic [3:0] ch2_rc_resistor_code_out,
   output logic [3:0] ch3_rc_resistor_code_out,
   output logic [3:0] ch4_rc_resistor_code_out,
   output logic [3:0] ch5_rc_resistor_code_out,
   output logic [filter_sel_pkg::NUM_CH-1:0][5:0] resistor_leg_out,
   output logic [filter_sel_pkg::NUM_CH-1:0] code_undefined_out
);
   import filter_sel_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // address and code decoding

   // true when the address falls inside the six-register window
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      return (a >= OFS_CH0) && (a <= OFS_CH5);
   endfunction

   // channel index of an address inside the window
   function automatic logic [2:0] addr_to_ch(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - OFS_CH0;
      return d[2:0];
   endfunction

   // one-hot resistor leg for a select code
   function automatic logic [5:0] code_to_leg(input logic [3:0] c);
      logic [5:0] leg;
      case (c)
         CODE_60R: leg = LEG_60R;
         CODE_5K6: leg = LEG_5K6;
         CODE_11K2: leg = LEG_11K2;
         CODE_22K2: leg = LEG_22K2;
         CODE_44K4: leg = LEG_44K4;
         CODE_104K: leg = LEG_104K;
         default: leg = LEG_NONE;
      endcase
      return leg;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // code store

   code_store_if cs ();

   code_store #(
      .CHANNELS(NUM_CH)
   ) u_store (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .port(cs.store)
   );

   // only bits 3:0 reach the store, upper write bits are dropped
   assign cs.wr_en = reg_wr_in && addr_hit(reg_addr_in);
   assign cs.wr_ch = addr_to_ch(reg_addr_in);
   assign cs.wr_code = reg_wdata_in[CODE_MSB:CODE_LSB];
   assign cs.rd_ch = addr_to_ch(reg_addr_in);

   ////////////////////////////////////////////////////////////////////////
   // read pipeline and analog select outputs

   logic rd_pend;
   logic rd_hit;
   logic [REG_W-1:0] rdata;
   logic rvalid;
   logic [NUM_CH-1:0][3:0] code_q;
   logic [NUM_CH-1:0][5:0] leg_q;
   logic [NUM_CH-1:0] undef_q;
   logic next_rd_pend;
   logic next_rd_hit;
   logic [REG_W-1:0] next_rdata;
   logic next_rvalid;
   logic [NUM_CH-1:0][3:0] next_code_q;
   logic [NUM_CH-1:0][5:0] next_leg_q;
   logic [NUM_CH-1:0] next_undef_q;

   // read answers two edges after the request, upper nibble zero
   always_comb
   begin
      next_rd_pend = reg_rd_in;
      next_rd_hit = reg_rd_in && addr_hit(reg_addr_in);
      next_rvalid = rd_pend;
      next_rdata = rdata;
      if (rd_pend)
      begin
         next_rdata = rd_hit ? {RSVD_VALUE, cs.rd_code}
                             : UNMAPPED_READ;
      end
      for (int c = 0; c < NUM_CH; c++)
      begin
         next_code_q[c] = cs.codes[c];
         next_leg_q[c] = code_to_leg(cs.codes[c]);
         next_undef_q[c] = (code_to_leg(cs.codes[c]) == LEG_NONE);
      end
   end

   // reset selects the 60 ohm leg on every channel
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_pend <= 1'b0;
         rd_hit <= 1'b0;
         rvalid <= 1'b0;
         rdata <= FILTER_RESET;
         code_q <= '0;
         leg_q <= {NUM_CH{LEG_60R}};
         undef_q <= '0;
      end
      else
      begin
         rd_pend <= next_rd_pend;
         rd_hit <= next_rd_hit;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         code_q <= next_code_q;
         leg_q <= next_leg_q;
         undef_q <= next_undef_q;
      end
   end

   // ports straight from the flops
   assign reg_rdata_out = rdata;
   assign reg_rvalid_out = rvalid;
   assign ch0_rc_resistor_code_out = code_q[0];
   assign ch1_rc_resistor_code_out = code_q[1];
   assign ch2_rc_resistor_code_out = code_q[2];
   assign ch3_rc_resistor_code_out = code_q[3];
   assign ch4_rc_resistor_code_out = code_q[4];
   assign ch5_rc_resistor_code_out = code_q[5];
   assign resistor_leg_out = leg_q;
   assign code_undefined_out = undef_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence wr_hit_s;
      reg_wr_in && addr_hit(reg_addr_in);
   endsequence
   sequence quiet_s;
      !reg_wr_in;
   endsequence
   sequence rd_hit_s;
      reg_rd_in && addr_hit(reg_addr_in);
   endsequence
   sequence rd_miss_s;
      reg_rd_in && !addr_hit(reg_addr_in);
   endsequence

   write_reaches_out_a: assert property (
      wr_hit_s ##1 quiet_s |=> code_q[$past(addr_to_ch(reg_addr_in), 2)]
         == $past(reg_wdata_in[3:0], 2))
      else $error("written code did not reach the channel output");

   low_60r_a: assert property (
      (code_q[0] == CODE_60R) |-> (leg_q[0] == LEG_60R)
         && !undef_q[0])
      else $error("code 0 did not select the 60 ohm leg");

   mid_legs_a: assert property (
      (code_q[2] == CODE_11K2) |-> (leg_q[2] == LEG_11K2))
      else $error("code 6 did not select the 11.2 k leg");

   high_legs_a: assert property (
      (code_q[3] == CODE_104K) |-> (leg_q[3] == LEG_104K))
      else $error("code 9 did not select the 104 k leg");

   rsvd_zero_a: assert property (
      reg_rvalid_out |-> (reg_rdata_out[7:4] == RSVD_VALUE))
      else $error("reserved bits read nonzero");

   ch1_map_a: assert property (
      reg_rd_in && (reg_addr_in == OFS_CH1) |-> ##2 reg_rvalid_out
         && (reg_rdata_out[3:0] == $past(cs.codes[1], 2)))
      else $error("read at channel 1 offset returned wrong code");

   ch0_only_a: assert property (
      reg_wr_in && (reg_addr_in == OFS_CH0) |=>
         $stable(cs.codes[NUM_CH-1:1]))
      else $error("write to channel 0 offset touched another channel");

   reset_value_a: assert property (
      disable iff (1'b0) $rose(rst_n_in) |-> (code_q == '0)
         && (leg_q == {NUM_CH{LEG_60R}}))
      else $error("select codes not zero after reset");

   // a read inside the bank is answered two edges after it is taken
   read_answer_a: assert property (
      rd_hit_s |-> ##2 reg_rvalid_out)
      else $error("register read not answered two edges after request");

   read_miss_a: assert property (
      rd_miss_s |-> ##2 reg_rvalid_out
         && (reg_rdata_out == UNMAPPED_READ))
      else $error("read outside the bank did not answer zero");

   rvalid_cause_a: assert property (
      reg_rvalid_out |-> $past(reg_rd_in, 2))
      else $error("read answer appeared without a request");

   miss_write_a: assert property (
      reg_wr_in && !addr_hit(reg_addr_in) |=> $stable(cs.codes))
      else $error("write outside the bank changed a stored code");

   upper_legs_a: assert property (
      (code_q[4] == CODE_44K4) |-> (leg_q[4] == LEG_44K4)
         && !undef_q[4])
      else $error("code 8 did not select the 44.4 k leg");

   low_legs_a: assert property (
      (code_q[5] == CODE_5K6) |-> (leg_q[5] == LEG_5K6)
         && !undef_q[5])
      else $error("code 5 did not select the 5.6 k leg");
endmodule

// ==== host_model.sv ====
// host-side model that drives the register strobe port
`timescale 1ns/1ns
module host_model
(
   input wire logic clk_in,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out
);
   initial
   begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   // one access held for one edge, released address and data lines show the inverse value, both strobes drop to 0
   task automatic access(input logic wr, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge clk_in);
      wr_out = wr;
      rd_out = !wr;
      addr_out = a;
      wdata_out = d; // only a scenario asks for codes off the list
      @(negedge clk_in);
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
endmodule

// ==== test_output_filter_select_regs.sv ====
// self-checking bench for the filter select register bank
`timescale 1ns/1ns
`define CHECK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module test_output_filter_select_regs;
   import filter_sel_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   logic [5:0][3:0] code_arr;
   logic [5:0][5:0] legs;
   logic [5:0] undef;
   logic [7:0] exp_q[$];
   logic [7:0] exp_v;
   logic [3:0] codes [6] = '{CODE_60R, CODE_5K6, CODE_11K2, CODE_22K2,
      CODE_44K4, CODE_104K};
   int seed = 21;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   host_model host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata));
   output_filter_select_regs uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .ch0_rc_resistor_code_out(code_arr[0]),
      .ch1_rc_resistor_code_out(code_arr[1]),
      .ch2_rc_resistor_code_out(code_arr[2]),
      .ch3_rc_resistor_code_out(code_arr[3]),
      .ch4_rc_resistor_code_out(code_arr[4]),
      .ch5_rc_resistor_code_out(code_arr[5]),
      .resistor_leg_out(legs), .code_undefined_out(undef));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         close_out();
      end
   end
   // read answers are matched against the oldest note
   always @(negedge clk_in)
   begin
      if (rvalid === 1'b1)
      begin
         // an answer nobody asked for is always a mismatch
         if (exp_q.size() == 0)
            `CHECK(rvalid, 1'b0)
         else
         begin
            exp_v = exp_q.pop_front();
            `CHECK(rdata, exp_v)
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask
   task automatic check_ch(input int ch, input logic [3:0] c,
      input logic [5:0] l, input logic u);
      `CHECK(code_arr[ch], c)
      `CHECK(legs[ch], l)
      `CHECK(undef[ch], u)
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (20) @(negedge clk_in);
      rst_n_in = 1'b1;
      for (int ch = 0; ch < 6; ch++)
      begin
         check_ch(ch, 4'h0, LEG_60R, 1'b0);
         rd_reg(OFS_CH0 + 8'(ch), FILTER_RESET);
      end
      $display("test reset done");
      // every listed code on every channel, junk in the upper nibble
      for (int ch = 0; ch < 6; ch++)
         for (int i = 0; i < 6; i++)
         begin
            host.access(1'b1, OFS_CH0 + 8'(ch),
               {4'($random(seed)), codes[i]});
            @(negedge clk_in);
            check_ch(ch, codes[i], LEG_60R << i, 1'b0);
            rd_reg(OFS_CH0 + 8'(ch), {RSVD_VALUE, codes[i]});
         end
      $display("test codes done");
      // a code off the list is stored but enables no leg
      host.access(1'b1, OFS_CH3, 8'hfb);
      @(negedge clk_in);
      check_ch(3, 4'hb, LEG_NONE, 1'b1);
      rd_reg(OFS_CH3, 8'h0b);
      $display("test undefined done");
      // neighbours of the bank are not part of it
      host.access(1'b1, 8'h1c, 8'h05);
      host.access(1'b1, 8'h23, 8'h06);
      rd_reg(8'h1c, 8'h00);
      rd_reg(8'h23, 8'h00);
      check_ch(0, CODE_104K, LEG_104K, 1'b0);
      check_ch(5, CODE_104K, LEG_104K, 1'b0);
      repeat (4) @(negedge clk_in);
      `CHECK(exp_q.size(), 0)
      $display("test unmapped done");
      // reset in mid-run returns every channel to the 60 ohm code
      rst_n_in = 1'b0;
      @(negedge clk_in);
      for (int ch = 0; ch < 6; ch++)
         check_ch(ch, CODE_60R, LEG_60R, 1'b0);
      rst_n_in = 1'b1;
      rd_reg(OFS_CH5, FILTER_RESET);
      repeat (4) @(negedge clk_in);
      `CHECK(exp_q.size(), 0)
      $display("test mid reset done");
      close_out();
   end
endmodule
